// ==== rtl/mmd_pkg.sv ====
// Behaviour
// - integer mode ratio spans 32 to 1048575 input cycles per output
// - fractional mode instantaneous ratio spans 36 to 1048571
// - output pulse width is whole RF periods, set by bits 14:12 of 00h
// - every edge of both outputs, positive and negative, is retimed to a rising rf edge
// - chip address is msb strap, mid strap, lsb strap
// - straps are captured at power-up and every reset, then held
// - open strap reads one through pull-up; grounded strap gives zero
// - host loads companion address into 09h; device watches it too
// - companion transfers needing local action update local registers
// - 09h holding own chip address disables companion snooping
// - integer ratio comes from bits 19:0 of register 05h
package mmd_pkg;
  // serial frame: rw, register address, chip address, data (msb first)
  localparam int          FRAME_BITS   = 34;
  localparam int          HDR_BITS     = 10;
  localparam int          DATA_W       = 24;
  localparam logic [5:0]  FRAME_CNT    = 6'h22;
  localparam logic [5:0]  HDR_CNT      = 6'h0A;

  // register offsets
  localparam logic [5:0]  REG_CTRL     = 6'h00;
  localparam logic [5:0]  REG_REF_DIV  = 6'h02;
  localparam logic [5:0]  REG_NINT     = 6'h05;
  localparam logic [5:0]  REG_COMP     = 6'h09;
  localparam logic [5:0]  REG_MODE     = 6'h0B;

  // companion register that also needs local action
  localparam logic [5:0]  COMP_REF_REG = 6'h02;

  // field positions
  localparam int          DUTY_LSB     = 12;
  localparam int          DUTY_MSB     = 14;
  localparam int          SOFT_RST_BIT = 5;
  localparam int          ID_LSB       = 16;
  localparam int          NINT_MSB     = 19;
  localparam int          FRAC_EN_BIT  = 0;

  // reset values
  localparam logic [2:0]  DUTY_RST     = 3'h3;
  localparam logic [19:0] NINT_RST     = 20'h00020;
  localparam logic [2:0]  COMP_RST     = 3'h0;
  localparam logic [23:0] REF_DIV_RST  = 24'h000001;
  localparam logic [2:0]  ADDR_RST     = 3'h7;
  localparam logic [1:0]  CAP_DLY      = 2'h3;

  // ratio limits
  localparam logic [19:0] INT_MIN      = 20'h00020;
  localparam logic [19:0] INT_MAX      = 20'hFFFFF;
  localparam logic [19:0] FRAC_MIN     = 20'h00024;
  localparam logic [19:0] FRAC_MAX     = 20'hFFFFB;

  typedef enum logic [1:0] {SPI_IDLE, SPI_HDR, SPI_DATA} spi_state_t;
endpackage

// ==== rtl/mmd_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module mmd_ctrl
  import mmd_pkg::*;
#(
  // arbitrary identification value
  parameter logic [7:0] CHIP_ID = 8'h5A
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // rf input, already squared by the input buffer
  input  wire logic              rf_in_pos,
  // modulator offset on the integer ratio
  input  wire logic signed [2:0] dither_step,
  // main serial port
  input  wire logic              spi_sck,
  input  wire logic              spi_sen_n,
  input  wire logic              spi_sdi,
  output var  logic              spi_sdo,
  // chip address straps
  input  wire logic              addr_strap_lsb,
  input  wire logic              addr_strap_mid,
  input  wire logic              addr_strap_msb,
  // divider outputs
  output var  logic              div_out_pos,
  output var  logic              div_out_neg,
  // local reference divider setting
  output var  logic [23:0]       ref_div_r
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] sck_s;
  logic [2:0] sen_s;
  logic [1:0] sdi_s;
  logic [2:0] rf_s;
  logic [2:0] strap_s0;
  logic [2:0] strap_s1;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_s    <= 3'h0;
      sen_s    <= 3'h7;
      sdi_s    <= 2'h0;
      rf_s     <= 3'h0;
      strap_s0 <= ADDR_RST;
      strap_s1 <= ADDR_RST;
    end else begin
      sck_s    <= {sck_s[1:0], spi_sck};
      sen_s    <= {sen_s[1:0], spi_sen_n};
      sdi_s    <= {sdi_s[0], spi_sdi};
      rf_s     <= {rf_s[1:0], rf_in_pos};
      strap_s0 <= {addr_strap_msb, addr_strap_mid, addr_strap_lsb};
      strap_s1 <= strap_s0;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic sen_rise;
  logic selected;
  logic rf_rise;
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];
  assign sen_rise = sen_s[1] & ~sen_s[2];
  assign selected = ~sen_s[1];
  assign rf_rise  = rf_s[1] & ~rf_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // chip address capture
  logic [2:0] own_addr_r;
  logic [1:0] cap_cnt_r;
  logic       cap_pend_r;
  logic       soft_rst_r;
  logic       capture;
  assign capture = cap_pend_r && (cap_cnt_r == 2'h0);

  // waits out the synchroniser so a stale reset value is never captured
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_cnt_r  <= CAP_DLY;
      cap_pend_r <= 1'b1;
      own_addr_r <= ADDR_RST;
    end else if (soft_rst_r) begin
      cap_cnt_r  <= CAP_DLY;
      cap_pend_r <= 1'b1;
    end else if (capture) begin
      own_addr_r <= strap_s1;
      cap_pend_r <= 1'b0;
    end else if (cap_pend_r) begin
      cap_cnt_r  <= cap_cnt_r - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial port
  spi_state_t  spi_st_r;
  logic [33:0] shift_r;
  logic [5:0]  bcnt_r;
  logic [23:0] rd_shift_r;
  logic [23:0] rd_val;
  logic [2:0]  duty_r;
  logic [19:0] nint_r;
  logic [2:0]  comp_r;
  logic        frac_en_r;
  logic        commit;
  logic        own_hit;
  logic        comp_hit;
  logic        wr_own;
  logic        wr_snoop;
  logic [5:0]  wr_reg;
  logic [23:0] wr_data;

  assign wr_reg   = shift_r[32:27];
  assign wr_data  = shift_r[23:0];
  assign commit   = sen_rise && (spi_st_r == SPI_DATA) &&
                    (bcnt_r == FRAME_CNT) && !shift_r[33];
  assign own_hit  = (shift_r[26:24] == own_addr_r);
  assign comp_hit = (shift_r[26:24] == comp_r) && (comp_r != own_addr_r);
  assign wr_own   = commit && own_hit;
  assign wr_snoop = commit && !own_hit && comp_hit &&
                    (wr_reg == COMP_REF_REG);

  always_comb begin
    rd_val = 24'h000000;
    case (shift_r[8:3])
      REG_CTRL: begin
        rd_val[ID_LSB+7:ID_LSB]     = CHIP_ID;
        rd_val[DUTY_MSB:DUTY_LSB]   = duty_r;
        rd_val[2:0]                 = own_addr_r;
      end
      REG_REF_DIV: rd_val = ref_div_r;
      REG_NINT:    rd_val[NINT_MSB:0] = nint_r;
      REG_COMP:    rd_val[2:0] = comp_r;
      REG_MODE:    rd_val[FRAC_EN_BIT] = frac_en_r;
      default:     rd_val = 24'h000000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spi_st_r <= SPI_IDLE;
      shift_r  <= 34'h000000000;
      bcnt_r   <= 6'h00;
    end else if (!selected) begin
      spi_st_r <= SPI_IDLE;
      bcnt_r   <= 6'h00;
    end else if (sck_rise) begin
      shift_r <= {shift_r[32:0], sdi_s[1]};
      if (bcnt_r != FRAME_CNT) begin
        bcnt_r <= bcnt_r + 6'h01;
      end
      case (spi_st_r)
        SPI_IDLE: spi_st_r <= SPI_HDR;
        SPI_HDR: begin
          if (bcnt_r == HDR_CNT - 6'h01) begin
            spi_st_r <= SPI_DATA;
          end
        end
        SPI_DATA: spi_st_r <= SPI_DATA;
        default:  spi_st_r <= SPI_IDLE;
      endcase
    end
  end

  // read data goes out on falling clock so the host samples on rising
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_shift_r <= 24'h000000;
      spi_sdo    <= 1'b0;
    end else if (!selected) begin
      spi_sdo    <= 1'b0;
    end else if (spi_st_r == SPI_DATA && bcnt_r == HDR_CNT && sck_fall) begin
      if (shift_r[9] && shift_r[2:0] == own_addr_r) begin
        spi_sdo    <= rd_val[23];
        rd_shift_r <= {rd_val[22:0], 1'b0};
      end else begin
        rd_shift_r <= 24'h000000;
      end
    end else if (spi_st_r == SPI_DATA && sck_fall) begin
      spi_sdo    <= rd_shift_r[23];
      rd_shift_r <= {rd_shift_r[22:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_own && (wr_reg == REG_CTRL) && wr_data[SOFT_RST_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      duty_r    <= DUTY_RST;
      nint_r    <= NINT_RST;
      comp_r    <= COMP_RST;
      ref_div_r <= REF_DIV_RST;
      frac_en_r <= 1'b0;
    end else if (soft_rst_r) begin
      duty_r    <= DUTY_RST;
      nint_r    <= NINT_RST;
      comp_r    <= COMP_RST;
      ref_div_r <= REF_DIV_RST;
      frac_en_r <= 1'b0;
    end else if (wr_own) begin
      case (wr_reg)
        REG_CTRL:    duty_r <= wr_data[DUTY_MSB:DUTY_LSB];
        REG_REF_DIV: ref_div_r <= wr_data;
        REG_NINT:    nint_r <= wr_data[NINT_MSB:0];
        REG_COMP:    comp_r <= wr_data[2:0];
        REG_MODE:    frac_en_r <= wr_data[FRAC_EN_BIT];
        default:     duty_r <= duty_r;
      endcase
    end else if (wr_snoop) begin
      ref_div_r <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ratio selection; clamping keeps the modulator inside the legal span
  logic signed [21:0] sum_s;
  logic [19:0]        ratio;

  always_comb begin
    sum_s = $signed({2'b00, nint_r}) +
            $signed({{19{dither_step[2]}}, dither_step});
    ratio = nint_r;
    if (frac_en_r) begin
      if (sum_s < $signed({2'b00, FRAC_MIN})) begin
        ratio = FRAC_MIN;
      end else if (sum_s > $signed({2'b00, FRAC_MAX})) begin
        ratio = FRAC_MAX;
      end else begin
        ratio = sum_s[19:0];
      end
    end else if (nint_r < INT_MIN) begin
      ratio = INT_MIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divider core
  logic [19:0] cnt_r;
  logic [2:0]  wid_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r       <= 20'h00000;
      wid_r       <= 3'h0;
      div_out_pos <= 1'b0;
      div_out_neg <= 1'b1;
    end else if (rf_rise) begin
      if (cnt_r == 20'h00000) begin
        cnt_r       <= ratio - 20'h00001;
        div_out_pos <= 1'b1;
        div_out_neg <= 1'b0;
        wid_r       <= duty_r;
      end else begin
        cnt_r <= cnt_r - 20'h00001;
        if (div_out_pos && wid_r == 3'h0) begin
          div_out_pos <= 1'b0;
          div_out_neg <= 1'b1;
        end else if (div_out_pos) begin
          wid_r <= wid_r - 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_int_range: assert property (@(posedge clk) disable iff (!rstn)
    !frac_en_r |-> (ratio >= INT_MIN && ratio <= INT_MAX))
    else $error("integer ratio out of span");

  a_frac_range: assert property (@(posedge clk) disable iff (!rstn)
    frac_en_r |-> (ratio >= FRAC_MIN && ratio <= FRAC_MAX))
    else $error("fractional ratio out of span");

  a_pulse_end: assert property (@(posedge clk) disable iff (!rstn)
    (rf_rise && div_out_pos && wid_r == 3'h0 && cnt_r != 20'h00000)
    |=> !div_out_pos)
    else $error("pulse outlived its width");

  a_rise_on_rf: assert property (@(posedge clk) disable iff (!rstn)
    $rose(div_out_pos) |-> ($past(rf_rise) && !div_out_neg))
    else $error("output edge not retimed to rf edge");

  a_strap_order: assert property (@(posedge clk) disable iff (!rstn)
    (capture && !soft_rst_r) |=> own_addr_r == $past(strap_s1))
    else $error("chip address not captured from straps");

  a_addr_hold: assert property (@(posedge clk) disable iff (!rstn)
    !capture |=> $stable(own_addr_r))
    else $error("chip address changed outside capture");

  a_strap_high: assert property (@(posedge clk) disable iff (!rstn)
    (capture && !soft_rst_r && strap_s1 == 3'h7) |=> own_addr_r == 3'h7)
    else $error("open straps did not read high");

  a_snoop_upd: assert property (@(posedge clk) disable iff (!rstn)
    (wr_snoop && !soft_rst_r) |=> ref_div_r == $past(wr_data))
    else $error("snooped command not applied");

  a_snoop_off: assert property (@(posedge clk) disable iff (!rstn)
    (commit && !own_hit && comp_r == own_addr_r && !soft_rst_r)
    |=> $stable(ref_div_r))
    else $error("snooping active with own address");

  a_nint_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr_own && wr_reg == REG_NINT && !soft_rst_r)
    |=> nint_r == $past(wr_data[19:0]))
    else $error("integer ratio write lost");

  a_one_pulse: assert property (@(posedge clk) disable iff (!rstn)
    (rf_rise && cnt_r != 20'h00000) |=> !$rose(div_out_pos))
    else $error("extra output pulse");

endmodule
`default_nettype wire

// ==== tb/spi_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  // clock
  input  wire logic clk,
  // serial lines
  output var  logic spi_sck,
  output var  logic spi_sen_n,
  output var  logic spi_sdi,
  input  wire logic spi_sdo
);
  // five clocks per half period leaves margin over the three needed
  localparam int HALF = 5;

  initial begin
    spi_sck = 1'b0;
    spi_sen_n = 1'b1;
    spi_sdi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one frame: read data is sampled just before each rising sck
  task automatic xfer(input logic rw, input logic [5:0] ra,
      input logic [2:0] ca, input logic [23:0] wd, output logic [23:0] rd);
    logic [33:0] f;
    f = {rw, ra, ca, wd};
    rd = 24'h000000;
    @(negedge clk);
    spi_sen_n = 1'b0;
    for (int i = 33; i >= 0; i--) begin
      spi_sdi = f[i];
      repeat (HALF) @(negedge clk);
      if (i < 24) rd[i] = spi_sdo;
      spi_sck = 1'b1;
      repeat (HALF) @(negedge clk);
      spi_sck = 1'b0;
    end
    spi_sen_n = 1'b1;
    // a released data line must not keep looking valid
    spi_sdi = ~spi_sdi;
    repeat (HALF + 4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/multimodulus_divider_addressing_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module multimodulus_divider_addressing_test;
  import mmd_pkg::*;
  // arbitrary identification value
  localparam logic [7:0] ID_VAL = 8'hC3;
  logic              clk, rstn, rf_in_pos, sck, sen_n, sdi, sdo, pos, neg;
  logic              s_lsb, s_mid, s_msb, bad;
  logic signed [2:0] dither;
  logic [23:0]       ref_div, rd, rnd_d;
  logic [31:0]       lfsr_r = 32'h18D64519;
  int                err_count = 0, num_checks = 0, cyc = 0;
  int                rf_cnt = 0, rf_ph = 0, r0, f0, r1, n;

  mmd_ctrl #(.CHIP_ID(ID_VAL)) i_mmd_ctrl (
    .clk(clk), .rstn(rstn), .rf_in_pos(rf_in_pos), .dither_step(dither),
    .spi_sck(sck), .spi_sen_n(sen_n), .spi_sdi(sdi), .spi_sdo(sdo),
    .addr_strap_lsb(s_lsb), .addr_strap_mid(s_mid),
    .addr_strap_msb(s_msb), .div_out_pos(pos), .div_out_neg(neg),
    .ref_div_r(ref_div));
  spi_host i_spi_host (.clk(clk), .spi_sck(sck), .spi_sen_n(sen_n),
    .spi_sdi(sdi), .spi_sdo(sdo));

  ////////////////////////////////////////////////////////////////////////
  initial clk = 1'b0;
  always #20 clk = ~clk;
  // rf input: three clocks high, three low, counted at each rise
  always @(negedge clk) begin
    rf_ph = rf_ph + 1;
    if (rf_ph == 3) begin
      rf_ph = 0;
      rf_in_pos = ~rf_in_pos;
      if (rf_in_pos) rf_cnt++;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // reference model of the ratio actually used
  function automatic int ratio_of(input int nv, input bit frac, input int d);
    int r, lo, hi;
    r = frac ? nv + d : nv;
    lo = frac ? 36 : 32;
    hi = frac ? 1048571 : 1048575;
    if (r < lo) r = lo;
    if (r > hi) r = hi;
    return r;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [2:0] ca, input logic [5:0] ra,
      input logic [23:0] d);
    i_spi_host.xfer(1'b0, ra, ca, d, rd);
  endtask
  task automatic rdr(input logic [2:0] ca, input logic [5:0] ra);
    i_spi_host.xfer(1'b1, ra, ca, 24'h000000, rd);
  endtask
  task automatic wait_pos(input logic lv);
    int k;
    k = 0;
    while (pos !== lv && k < 20000) begin
      @(negedge clk);
      if (neg !== ~pos) bad = 1'b1;
      k++;
    end
    if (k == 20000) check("pulse wait", pos, lv);
  endtask
  // ratio is taken at pulse start, so the first rise after a write counts
  task automatic meas(input int per, input int hi);
    bad = 1'b0;
    wait_pos(1'b0);
    wait_pos(1'b1);
    r0 = rf_cnt;
    wait_pos(1'b0);
    f0 = rf_cnt;
    wait_pos(1'b1);
    r1 = rf_cnt;
    check("period", 32'(r1 - r0), 32'(per));
    check("width", 32'(f0 - r0), 32'(hi));
    check("neg complement", bad, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    rf_in_pos = 1'b0;
    dither = 3'sh0;
    // open lsb strap reads high, mid strap grounded
    s_lsb = 1'b1;
    s_mid = 1'b0;
    s_msb = 1'b1;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    rdr(3'h5, REG_CTRL);
    check("id", rd[23:16], ID_VAL);
    check("duty", rd[14:12], DUTY_RST);
    check("own address", rd[2:0], 3'h5);
    check("ref div", ref_div, REF_DIV_RST);
    rdr(3'h2, REG_CTRL);
    check("foreign read", rd, 0);
    rdr(3'h5, 6'h1F);
    check("unmapped read", rd, 0);
    $display("test reset done");
    for (int d = 0; d < 8; d++) begin
      wr(3'h5, REG_CTRL, {9'h000, 3'(d), 12'h000});
      meas(ratio_of(32, 1'b0, 0), d + 1);
    end
    // 40 percent needs ratio 20 or less: keep widest
    wr(3'h5, REG_NINT, 24'h000028);
    meas(ratio_of(40, 1'b0, 0), 8);
    rdr(3'h5, REG_NINT);
    check("nint readback", rd, 24'h000028);
    wr(3'h5, REG_NINT, 24'h000008);
    meas(ratio_of(8, 1'b0, 0), 8);
    $display("test integer done");
    wr(3'h5, REG_MODE, 24'h000001);
    for (int k = 0; k < 4; k++) begin
      lfsr_r = lfsr(lfsr_r);
      dither = lfsr_r[2:0];
      n = (k < 2) ? 36 : 40;
      wr(3'h5, REG_NINT, 24'(n));
      meas(ratio_of(n, 1'b1, int'(dither)), 8);
    end
    wr(3'h5, REG_MODE, 24'h000000);
    dither = 3'sh0;
    $display("test fractional done");
    wr(3'h5, REG_COMP, 24'h000003);
    rdr(3'h5, REG_COMP);
    check("companion reg", rd[2:0], 3'h3);
    lfsr_r = lfsr(lfsr_r);
    rnd_d = lfsr_r[23:0];
    wr(3'h3, COMP_REF_REG, rnd_d);
    check("snooped ref div", ref_div, rnd_d);
    wr(3'h3, REG_NINT, 24'h000030);
    rdr(3'h5, REG_NINT);
    check("snoop other reg", rd, 24'h000028);
    wr(3'h4, COMP_REF_REG, ~rnd_d);
    check("other chip ignored", ref_div, rnd_d);
    wr(3'h5, REG_COMP, 24'h000005);
    wr(3'h3, COMP_REF_REG, ~rnd_d);
    check("snoop disabled", ref_div, rnd_d);
    rnd_d = ~rnd_d;
    wr(3'h5, REG_REF_DIV, rnd_d);
    rdr(3'h5, REG_REF_DIV);
    check("own ref div", rd, rnd_d);
    $display("test companion done");
    s_lsb = 1'b0;
    s_mid = 1'b1;
    s_msb = 1'b0;
    repeat (4) @(negedge clk);
    wr(3'h5, REG_CTRL, 24'h000020);
    repeat (12) @(negedge clk);
    rdr(3'h2, REG_CTRL);
    check("soft reset address", rd[2:0], 3'h2);
    check("soft reset duty", rd[14:12], DUTY_RST);
    check("soft reset ref div", ref_div, REF_DIV_RST);
    // grounded lsb, open mid and msb; differs from the reset value
    s_lsb = 1'b0;
    s_mid = 1'b1;
    s_msb = 1'b1;
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    rdr(3'h6, REG_CTRL);
    check("reset address", rd[2:0], 3'h6);
    // all straps open, recaptured by soft reset from address 6
    s_lsb = 1'b1;
    repeat (4) @(negedge clk);
    wr(3'h6, REG_CTRL, 24'h000020);
    repeat (12) @(negedge clk);
    rdr(3'h7, REG_CTRL);
    check("open straps", rd[2:0], 3'h7);
    $display("test straps done");
    finish_test();
  end
endmodule
`default_nettype wire
